// file: sdio_pkg.sv
package sdio_pkg;

  localparam int CLOCK_HZ = 20_000_000;
  localparam int CLEAR_MIN_MS = 10;
  localparam int CLEAR_MIN_CYC = (CLOCK_HZ / 1000) * CLEAR_MIN_MS;
  localparam int ALARM_DELAY_S = 1;
  localparam int ALARM_DELAY_CYC = CLOCK_HZ * ALARM_DELAY_S;
  localparam int FILTER_LEN = 3;
  localparam int SPEED_W = 16;
  localparam int DROOP_W = 24;
  localparam int RANGE_W = 16;
  localparam int DELAY_W = 24;
  localparam logic [SPEED_W-1:0] SPEED_LIMIT_RST = 16'h0000;
  localparam logic [DROOP_W-1:0] DROOP_RST = 24'h000000;
  localparam logic [3:0] TOUGH_DRIVE_ON = 4'h1;

  typedef enum logic {MODE_POSITION, MODE_SPEED} sdio_mode_t;

  typedef struct packed {
    logic [2:0] speed_select;
    logic       proportional_loop_select;
    logic       torque_limit_select;
    logic       forced_stop_in;
    logic       droop_clear_in;
    logic       gain_change_in;
    logic       control_mode_change_in;
    logic       servo_on_in;
  } sdio_din_t;

  localparam int DIN_W = $bits(sdio_din_t);

  typedef struct packed {
    logic       torque_mode;
    logic       position_mode;
    logic       mode_change_enable;
    logic       level_clear;
    logic [3:0] tough_drive_select_setting;
    logic       tough_drive_active;
    logic       motor_ready;
    logic       protective_trip;
    logic       forced_stop_reset_req;
  } sdio_cfg_t;

  typedef struct packed {
    logic       proportional_loop;
    logic       alternate_gains;
    logic       torque_limit_two;
    logic       base_off;
    logic       dynamic_brake;
    logic       droop_clear_pulse;
    logic       filter_flush;
    sdio_mode_t active_mode;
  } sdio_ctl_t;

endpackage

// file: sdio_filter.sv
`timescale 1ns/1ps
module sdio_filter
#(
  parameter int LEN = 3
)
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic raw_in,
  output      logic clean_out
);
  import sdio_pkg::*;

  logic           meta_reg, meta_next;
  logic           sync_reg, sync_next;
  logic [LEN-1:0] hist_reg, hist_next;
  logic           out_reg,  out_next;

  initial
  begin
    if (LEN < 2)
      $error("sdio_filter: LEN must be at least 2");
  end

  // Level only changes after LEN equal samples; lone spikes vanish
  always_comb
  begin
    meta_next = raw_in;
    sync_next = meta_reg;
    hist_next = {hist_reg[LEN-2:0], sync_reg};
    out_next  = out_reg;
    if (&hist_reg)
      out_next = 1'b1;
    else if (~|hist_reg)
      out_next = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      hist_reg <= '0;
      out_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      hist_reg <= hist_next;
      out_reg  <= out_next;
    end
  end

  assign clean_out = out_reg;

endmodule

// file: sdio_core.sv
`timescale 1ns/1ps
module sdio_core
#(
  parameter int ALARM_CYC = sdio_pkg::ALARM_DELAY_CYC
)
(
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  input  wire logic                            clk_en,
  input  wire sdio_pkg::sdio_din_t             din,
  input  wire sdio_pkg::sdio_cfg_t             cfg,
  input  wire logic [7:0][sdio_pkg::SPEED_W-1:0] speed_limit_table,
  input  wire logic [sdio_pkg::DROOP_W-1:0]    droop_in,
  input  wire logic [sdio_pkg::RANGE_W-1:0]    in_position_range_setting,
  input  wire logic [sdio_pkg::DELAY_W-1:0]    tough_drive_detail_setting,
  output      sdio_pkg::sdio_ctl_t             ctl,
  output      logic [sdio_pkg::SPEED_W-1:0]    speed_limit,
  output      logic [sdio_pkg::DROOP_W-1:0]    droop_count,
  output      logic                            alarm_free_out,
  output      logic                            ready_out,
  output      logic                            in_position_out
);
  import sdio_pkg::*;

  initial
  begin
    if (ALARM_CYC < 1)
      $error("sdio_core: ALARM_CYC must be at least 1");
  end

  logic [DIN_W-1:0] din_raw;
  logic [DIN_W-1:0] din_clean;
  sdio_din_t        f;

  assign din_raw = din;

  genvar g;
  generate
    for (g = 0; g < DIN_W; g++)
    begin : g_filt
      sdio_filter #(.LEN(FILTER_LEN)) u_filt
      (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .raw_in    (din_raw[g]),
        .clean_out (din_clean[g])
      );
    end
  endgenerate

  assign f = din_clean;

  logic [SPEED_W-1:0] speed_reg,   speed_next;
  sdio_ctl_t          ctl_reg,     ctl_next;
  logic               estop_reg,   estop_next;
  logic               clr_d_reg,   clr_d_next;
  logic [DROOP_W-1:0] droop_reg,   droop_next;
  logic [31:0]        alarm_cnt_reg, alarm_cnt_next;
  logic               alarm_reg,   alarm_next;
  logic               ready_reg,   ready_next;
  logic [DELAY_W-1:0] td_cnt_reg,  td_cnt_next;
  logic               inp_reg,     inp_next;
  logic               clr_rise;
  logic               clr_now;
  logic               in_range;
  logic [DROOP_W-1:0] droop_mag;

  assign clr_rise = f.droop_clear_in & ~clr_d_reg;
  // Edge clear in position mode; level mode holds clear while asserted
  assign clr_now  = cfg.position_mode &
                    (clr_rise | (cfg.level_clear & f.droop_clear_in));
  assign droop_mag = droop_reg[DROOP_W-1] ? DROOP_W'(-droop_reg) : droop_reg;
  assign in_range  = droop_mag <= DROOP_W'(in_position_range_setting);

  always_comb
  begin
    speed_next = speed_reg;
    if (cfg.torque_mode)
      speed_next = speed_limit_table[f.speed_select];
    ctl_next = ctl_reg;
    ctl_next.proportional_loop = f.proportional_loop_select;
    ctl_next.torque_limit_two  = f.torque_limit_select;
    ctl_next.alternate_gains   = f.gain_change_in;
    ctl_next.droop_clear_pulse = clr_now;
    ctl_next.filter_flush      = clr_now;
    ctl_next.active_mode = MODE_POSITION;
    if (cfg.mode_change_enable && f.control_mode_change_in)
      ctl_next.active_mode = MODE_SPEED;
    else if (!cfg.mode_change_enable && !cfg.position_mode)
      ctl_next.active_mode = MODE_SPEED;
    // Stop latches; only releases once input closed and reset asked
    estop_next = estop_reg;
    if (!f.forced_stop_in)
      estop_next = 1'b1;
    else if (cfg.forced_stop_reset_req)
      estop_next = 1'b0;
    ctl_next.base_off      = estop_next | cfg.protective_trip;
    ctl_next.dynamic_brake = estop_next;
    clr_d_next = f.droop_clear_in;
    droop_next = clr_now ? DROOP_RST : droop_in;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      speed_reg <= SPEED_LIMIT_RST;
      ctl_reg   <= '0;
      estop_reg <= 1'b1;
      clr_d_reg <= 1'b0;
      droop_reg <= DROOP_RST;
    end
    else if (clk_en)
    begin
      speed_reg <= speed_next;
      ctl_reg   <= ctl_next;
      estop_reg <= estop_next;
      clr_d_reg <= clr_d_next;
      droop_reg <= droop_next;
    end
  end

  // Status outputs
  always_comb
  begin
    alarm_cnt_next = alarm_cnt_reg;
    alarm_next     = alarm_reg;
    if (cfg.protective_trip)
    begin
      alarm_next = 1'b0;
    end
    else if (alarm_cnt_reg < 32'(ALARM_CYC - 1))
    begin
      alarm_cnt_next = alarm_cnt_reg + 32'h00000001;
    end
    else
    begin
      alarm_next = 1'b1;
    end
    ready_next = f.servo_on_in & cfg.motor_ready & alarm_next &
                 ~ctl_next.base_off;
    td_cnt_next = '0;
    inp_next    = 1'b0;
    if (f.servo_on_in && in_range)
    begin
      // Tough drive holds off, but never past the limit setting
      if (cfg.tough_drive_select_setting == TOUGH_DRIVE_ON &&
          cfg.tough_drive_active &&
          td_cnt_reg < tough_drive_detail_setting)
      begin
        td_cnt_next = td_cnt_reg + DELAY_W'(1);
      end
      else
      begin
        td_cnt_next = td_cnt_reg;
        inp_next    = 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      alarm_cnt_reg <= 32'h00000000;
      alarm_reg     <= 1'b0;
      ready_reg     <= 1'b0;
      td_cnt_reg    <= '0;
      inp_reg       <= 1'b0;
    end
    else if (clk_en)
    begin
      alarm_cnt_reg <= alarm_cnt_next;
      alarm_reg     <= alarm_next;
      ready_reg     <= ready_next;
      td_cnt_reg    <= td_cnt_next;
      inp_reg       <= inp_next;
    end
  end

  assign ctl             = ctl_reg;
  assign speed_limit     = speed_reg;
  assign droop_count     = droop_reg;
  assign alarm_free_out  = alarm_reg;
  assign ready_out       = ready_reg;
  assign in_position_out = inp_reg;

  // Disabled in reset; a frozen enable only holds state, so the next-cycle (|=>) guards key on it
  AST_SPEED_SEL: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && cfg.torque_mode |=>
      speed_reg == $past(speed_limit_table[f.speed_select]))
    else $error("speed limit not taken from selected slot");

  AST_SPEED_HOLD: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && !cfg.torque_mode |=> $stable(speed_reg))
    else $error("speed limit moved outside torque mode");

  AST_PROP_LOOP: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en |=> ctl_reg.proportional_loop == $past(f.proportional_loop_select))
    else $error("proportional loop does not follow input");

  AST_ESTOP: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && !f.forced_stop_in |=> ctl_reg.base_off && ctl_reg.dynamic_brake)
    else $error("forced stop did not cut base");

  AST_ESTOP_HOLD: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && estop_reg && !cfg.forced_stop_reset_req |=> estop_reg)
    else $error("forced stop released without reset");

  AST_CLEAR: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && cfg.position_mode && clr_rise |=> droop_reg == DROOP_RST)
    else $error("droop not cleared on clear edge");

  AST_LEVEL_CLR: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && cfg.position_mode && cfg.level_clear && f.droop_clear_in |=>
      ctl_reg.droop_clear_pulse && droop_reg == DROOP_RST)
    else $error("level clear did not hold droop at zero");

  AST_FLUSH: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && clr_now |=> ctl_reg.filter_flush)
    else $error("filter flush not paired with clear");

  AST_GAIN: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en |=> ctl_reg.alternate_gains == $past(f.gain_change_in))
    else $error("gain set does not follow input");

  AST_MODE_SEL: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && cfg.mode_change_enable |=> ctl_reg.active_mode ==
      ($past(f.control_mode_change_in) ? MODE_SPEED : MODE_POSITION))
    else $error("control mode does not follow change input");

  AST_ALARM_TRIP: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && cfg.protective_trip |=> !alarm_free_out)
    else $error("alarm-free stayed on during trip");

  AST_ALARM_ON: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && !cfg.protective_trip && alarm_cnt_reg >= 32'(ALARM_CYC - 1)
      |=> alarm_free_out)
    else $error("alarm-free not raised after power-on delay");

  AST_READY: assert property (@(posedge clock)
    disable iff (sys_rst)
    ready_out |-> alarm_free_out && !ctl_reg.base_off)
    else $error("ready shown with alarm or base off");

  AST_INP_RANGE: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && !in_range |=> !in_position_out)
    else $error("in-position shown outside range");

  AST_INP_SON: assert property (@(posedge clock)
    disable iff (sys_rst)
    in_position_out |-> $past(f.servo_on_in))
    else $error("in-position without servo-on");

  AST_TD_LIMIT: assert property (@(posedge clock)
    disable iff (sys_rst)
    clk_en && f.servo_on_in && in_range &&
      td_cnt_reg >= tough_drive_detail_setting |=> in_position_out)
    else $error("tough drive delay ran past its limit");

  COV_ESTOP: cover property (@(posedge clock) ctl_reg.dynamic_brake);
  COV_CLEAR: cover property (@(posedge clock) ctl_reg.droop_clear_pulse);
  COV_INP: cover property (@(posedge clock) in_position_out);
  COV_ALARM: cover property (@(posedge clock) $rose(alarm_free_out));
  COV_TOUGH: cover property (@(posedge clock)
    in_position_out && td_cnt_reg != '0);

endmodule

// file: sdio_ctrl_model.sv
`timescale 1ns/1ps
module sdio_ctrl_model
#(
  parameter int CLEAR_CYC = sdio_pkg::CLEAR_MIN_CYC
)
(
  input  wire logic          clock,
  output sdio_pkg::sdio_din_t din
);
  import sdio_pkg::*;
  initial din = '0;
  task automatic put(input sdio_din_t v);
    @(negedge clock);
    din = v;
  endtask
  // Held for CLEAR_CYC cycles; only the default equals the minimum width
  task automatic clear_req();
    @(negedge clock);
    din.droop_clear_in = 1'b1;
    repeat (CLEAR_CYC) @(negedge clock);
    din.droop_clear_in = 1'b0;
  endtask
  // Long hold pairs torque limit with proportional loop
  task automatic hold(input logic on);
    @(negedge clock);
    din.torque_limit_select      = on;
    din.proportional_loop_select = on;
  endtask
endmodule

// file: test_sdio_core.sv
`timescale 1ns/1ps
module test_sdio_core;
  import sdio_pkg::*;
  logic                  clock;
  logic                  sys_rst;
  sdio_din_t             din;
  sdio_din_t             v;
  sdio_cfg_t             cfg;
  logic [7:0][15:0]      tbl;
  logic [23:0]           droop_in;
  logic [15:0]           rng;
  logic [23:0]           det;
  sdio_ctl_t             ctl;
  logic [15:0]           speed_limit;
  logic [23:0]           droop_count;
  logic                  alarm;
  logic                  ready;
  logic                  inpos;
  logic                  flush_seen;
  logic                  clk_en;
  int                    num_errors;
  int                    check_count;
  int                    cyc;

  // Clear width and alarm delay scaled down to keep the run short
  sdio_ctrl_model #(.CLEAR_CYC(12)) i_ctrl (.clock(clock), .din(din));
  sdio_core #(.ALARM_CYC(20)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(din), .cfg(cfg),
    .speed_limit_table(tbl), .droop_in(droop_in),
    .in_position_range_setting(rng), .tough_drive_detail_setting(det),
    .ctl(ctl), .speed_limit(speed_limit), .droop_count(droop_count),
    .alarm_free_out(alarm), .ready_out(ready), .in_position_out(inpos));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, well above the sum of all waits
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // Sampled mid-cycle, clear of the edge that launches it
  always @(negedge clock)
  begin
    if (ctl.filter_flush === 1'b1)
      flush_seen = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic set(input sdio_din_t nv);
    v = nv;
    i_ctrl.put(v);
  endtask

  initial
  begin
    sys_rst = 1'b1; cfg = '0; droop_in = 24'h000040; rng = 16'h0010;
    det = 24'h000004; flush_seen = 1'b0; num_errors = 0; check_count = 0;
    cyc = 0;
    clk_en = 1'b1;
    for (int i = 0; i < 8; i++) tbl[i] = 16'h0100 + 16'(i);
    wt(2);
    sys_rst = 1'b0;
    wt(10); chk(alarm, 0);
    wt(15); chk(alarm, 1);
    $display("test alarm delay done");
    v = '0;
    cfg.forced_stop_reset_req = 1'b1;
    wt(10); chk(ctl.base_off, 1);
    v.forced_stop_in = 1'b1; set(v);
    wt(10); chk(ctl.base_off, 0);
    cfg.forced_stop_reset_req = 1'b0;
    v.forced_stop_in = 1'b0; set(v);
    wt(10); chk({ctl.base_off, ctl.dynamic_brake}, 3);
    cfg.forced_stop_reset_req = 1'b1;
    wt(3); chk(ctl.base_off, 1);
    v.forced_stop_in = 1'b1; set(v);
    wt(10); chk(ctl.base_off, 0);
    cfg.protective_trip = 1'b1;
    wt(2); chk(alarm, 0);
    cfg.protective_trip = 1'b0;
    wt(2); chk(alarm, 1);
    $display("test stop and trip done");
    cfg.torque_mode = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      v.speed_select = 3'(c); set(v);
      wt(10); chk(speed_limit, tbl[c]);
    end
    $display("test speed codes done");
    v.gain_change_in = 1'b1; set(v);
    i_ctrl.hold(1'b1);
    wt(10); chk(ctl.proportional_loop, 1);
    chk(ctl.alternate_gains, 1);
    chk(ctl.torque_limit_two, 1);
    v = din; v.gain_change_in = 1'b0; v.proportional_loop_select = 1'b0;
    v.torque_limit_select = 1'b0; set(v);
    wt(10); chk({ctl.proportional_loop, ctl.alternate_gains}, 0);
    v.proportional_loop_select = 1'b1; set(v);
    v.proportional_loop_select = 1'b0; set(v);
    for (int i = 0; i < 10; i++)
    begin
      wt(1);
      chk(ctl.proportional_loop, 0);
    end
    cfg.mode_change_enable = 1'b1;
    wt(10); chk(ctl.active_mode, MODE_POSITION);
    v.control_mode_change_in = 1'b1; set(v);
    wt(10); chk(ctl.active_mode, MODE_SPEED);
    // Frozen core must not see the input until the enable returns
    clk_en = 1'b0;
    v.gain_change_in = 1'b1; set(v);
    wt(10); chk(ctl.alternate_gains, 0);
    clk_en = 1'b1;
    wt(10); chk(ctl.alternate_gains, 1);
    $display("test loop, gain, mode done");
    cfg.mode_change_enable = 1'b0; cfg.torque_mode = 1'b0;
    cfg.position_mode = 1'b1;
    fork
      i_ctrl.clear_req();
      begin
        wt(8);
        chk({ctl.droop_clear_pulse, droop_count}, 32'h01000000);
        chk(ctl.filter_flush, 1);
        wt(3);
        chk(ctl.droop_clear_pulse, 0);
      end
    join
    wt(10); chk(flush_seen, 1);
    cfg.level_clear = 1'b1;
    fork
      i_ctrl.clear_req();
      begin
        wt(11);
        chk({ctl.droop_clear_pulse, droop_count}, 32'h01000000);
      end
    join
    cfg.level_clear = 1'b0;
    $display("test clear done");
    cfg.motor_ready = 1'b1; droop_in = 24'h000008;
    v = din; v.servo_on_in = 1'b1; set(v);
    wt(10); chk({ready, inpos}, 3);
    droop_in = 24'hFFFFF8;
    wt(3); chk(inpos, 1);
    droop_in = 24'h000040;
    wt(3); chk(inpos, 0);
    cfg.tough_drive_select_setting = TOUGH_DRIVE_ON;
    cfg.tough_drive_active = 1'b1; droop_in = 24'h000008;
    wt(2); chk(inpos, 0);
    wt(8); chk(inpos, 1);
    v.servo_on_in = 1'b0; set(v);
    wt(10); chk({ready, inpos}, 0);
    $display("test ready and in-position done");
    give_verdict();
  end
endmodule
